// *** rtl/fip_map.svh ***
// Constants of the frame initialization packet: layout, field values and limits
`ifndef FIP_MAP_SVH
`define FIP_MAP_SVH
// ---------------------------------------------------------------
// Packet geometry
// ---------------------------------------------------------------
`define FIP_PKT_LAST     8'd187
`define FIP_HDR_LEN      8'd4
// ---------------------------------------------------------------
// Byte offsets within the packet
// ---------------------------------------------------------------
`define FIP_OFS_SCHEME   8'd4
`define FIP_OFS_LEN      8'd5
`define FIP_OFS_PTR      8'd6
`define FIP_OFS_FLAGS    8'd8
`define FIP_OFS_TS       8'd10
`define FIP_OFS_LAT      8'd13
`define FIP_OFS_SIG      8'd16
`define FIP_OFS_ALEN     8'd20
`define FIP_OFS_CRC      8'd21
`define FIP_OFS_CRC_LAST 8'd24
// ---------------------------------------------------------------
// Field values
// ---------------------------------------------------------------
`define FIP_SYNC_BYTE    8'h47
`define FIP_PID          13'h0015
`define FIP_HDR_FLAGS    3'h3
`define FIP_HDR_SCR_AFC  4'h1
`define FIP_SCHEME_SFN   8'h00
`define FIP_SEC_LEN      8'h13
`define FIP_SEC_LEN_MAX  8'hB6
`define FIP_TIME_MAX     24'h98967F
`define FIP_ADDR_NONE    8'h00
`define FIP_ADDR_GROUP   8'hFF
`define FIP_HANDHELD     1'b1
`define FIP_PAD          8'hFF
`define FIP_CRC_INIT     32'hFFFFFFFF
`define FIP_CRC_POLY     32'h04C11DB7
`endif

// *** rtl/fip_pkg.sv ***
// Generator types, and the checksum step shared by both ends of the packet link
`include "fip_map.svh"
package fip_pkg;
  typedef logic [7:0] fip_byte_t;
  typedef enum logic {FIP_IDLE, FIP_SEND} fip_gen_state_t;

  // One byte through the CRC-32 register, MSB first, no reflection
  function automatic logic [31:0] fip_crc_step(input logic [31:0] c, input fip_byte_t d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ `FIP_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

// *** rtl/fip_if.sv ***
// Byte stream link between the packet generator and the sync-side parser
`timescale 1ns/1ps
interface fip_if;
  logic [7:0] data;
  logic       sop;
  logic       valid;
  logic       ready;
  modport gen  (output data, output sop, output valid, input ready);
  modport sync (input data, input sop, input valid, output ready);
endinterface // fip_if

// *** rtl/fip_gen.sv ***
// Network adapter end: builds one 188-byte frame initialization packet per request
//
// Summary of operation
// - Packet is 4 header plus 184 data bytes.
// - Inserter sends exactly one packet per frame.
// - Fields follow header in fixed order, width.
// - Header carries packet identifier 0x15.
// - Start indicator and priority bits set.
// - Unscrambled, payload-only header control fields.
// - Code 0x00 single frequency network; others reserved.
// - Section length counts through CRC, max 182.
// - Pointer counts packets to next frame start.
// - Spacing flag 1 periodic, 0 aperiodic.
// - Receiver handles periodic and aperiodic insertion.
// - Handheld marker bit always one.
// - Timestamp in 100 ns, max 0x98967F.
// - Latency budget in 100 ns, max 0x98967F.
// - Adapter picks budget above worst network delay.
// - Fields apply next frame; signalling two later.
// - Signalling bits P0,P1 carry frame number.
// - Sync function mandatory with multi-frame superframes.
// - Address length 0x00 none, 0xFF multicast.
// - CRC zeroes decoder over all but padding.
`timescale 1ns/1ps
`include "fip_map.svh"
module fip_gen
  import fip_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_insert,
  input  wire logic [15:0] i_pointer,
  input  wire logic        i_periodic,
  input  wire logic [23:0] i_timestamp,
  input  wire logic [23:0] i_latency,
  input  wire logic [29:0] i_signal,
  output logic             o_busy,
  output logic [1:0]       o_frame_num,
  fip_if.gen               link
);
  import fip_pkg::*;

  fip_gen_state_t state_ff;
  logic [7:0]     idx_ff;
  logic [31:0]    crc_ff;
  logic [3:0]     cc_ff;
  logic [1:0]     fnum_ff;
  logic [15:0]    ptr_ff;
  logic           per_ff;
  logic [23:0]    ts_ff;
  logic [23:0]    lat_ff;
  logic [29:0]    sig_ff;
  fip_byte_t      nxt_byte;
  logic           push;
  logic [8:0]     head_ff;
  logic           head_vld_ff;
  logic [8:0]     tail_ff;
  logic           tail_vld_ff;
  logic           pop;

  // ---------------------------------------------------------------
  // Request capture and packet sequencing
  // ---------------------------------------------------------------
  // Push only while the spare slot is free, so a stalled parser stalls us
  assign push = (state_ff == FIP_SEND) && !tail_vld_ff;

  // Sequencer; one request per frame is the caller's duty, extra ones during FIP_SEND drop
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= FIP_IDLE;
      idx_ff   <= 8'h00;
    end else begin
      unique case (state_ff)
        FIP_IDLE: begin
          if (i_insert) begin
            state_ff <= FIP_SEND;
            idx_ff   <= 8'h00;
          end
        end
        FIP_SEND: begin
          if (push) begin
            idx_ff <= idx_ff + 8'h01;
            if (idx_ff == `FIP_PKT_LAST) begin
              state_ff <= FIP_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Field snapshot at request time so the caller may change inputs mid-packet
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_ff <= 16'h0000;
      per_ff <= 1'b0;
      ts_ff  <= 24'h000000;
      lat_ff <= 24'h000000;
      sig_ff <= 30'h00000000;
    end else if (state_ff == FIP_IDLE && i_insert) begin
      ptr_ff <= i_pointer;
      per_ff <= i_periodic;
      ts_ff  <= (i_timestamp > `FIP_TIME_MAX) ? `FIP_TIME_MAX : i_timestamp;
      lat_ff <= (i_latency > `FIP_TIME_MAX) ? `FIP_TIME_MAX : i_latency;
      sig_ff <= i_signal;
    end
  end

  // Continuity counter and frame number advance once per finished packet
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cc_ff   <= 4'h0;
      fnum_ff <= 2'h0;
    end else if (push && idx_ff == `FIP_PKT_LAST) begin
      cc_ff   <= cc_ff + 4'h1;
      fnum_ff <= fnum_ff + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Byte content by position
  // ---------------------------------------------------------------
  // Reserved spacing bits are sent as zero; no addressing loop is generated
  always_comb begin
    nxt_byte = `FIP_PAD;
    unique case (idx_ff)
      8'd0:  nxt_byte = `FIP_SYNC_BYTE;
      8'd1:  nxt_byte = {`FIP_HDR_FLAGS, 5'(`FIP_PID >> 8)};
      8'd2:  nxt_byte = 8'(`FIP_PID & 13'h00FF);
      8'd3:  nxt_byte = {`FIP_HDR_SCR_AFC, cc_ff};
      8'd4:  nxt_byte = `FIP_SCHEME_SFN;
      8'd5:  nxt_byte = `FIP_SEC_LEN;
      8'd6:  nxt_byte = ptr_ff[15:8];
      8'd7:  nxt_byte = ptr_ff[7:0];
      8'd8:  nxt_byte = {per_ff, 7'h00};
      8'd9:  nxt_byte = {7'h00, `FIP_HANDHELD};
      8'd10: nxt_byte = ts_ff[23:16];
      8'd11: nxt_byte = ts_ff[15:8];
      8'd12: nxt_byte = ts_ff[7:0];
      8'd13: nxt_byte = lat_ff[23:16];
      8'd14: nxt_byte = lat_ff[15:8];
      8'd15: nxt_byte = lat_ff[7:0];
      8'd16: nxt_byte = {fnum_ff, sig_ff[29:24]};
      8'd17: nxt_byte = sig_ff[23:16];
      8'd18: nxt_byte = sig_ff[15:8];
      8'd19: nxt_byte = sig_ff[7:0];
      8'd20: nxt_byte = `FIP_ADDR_NONE;
      8'd21: nxt_byte = crc_ff[31:24];
      8'd22: nxt_byte = crc_ff[23:16];
      8'd23: nxt_byte = crc_ff[15:8];
      8'd24: nxt_byte = crc_ff[7:0];
      default: nxt_byte = `FIP_PAD;
    endcase
  end

  // ---------------------------------------------------------------
  // Checksum
  // ---------------------------------------------------------------
  // Header included; register frozen once the CRC bytes start going out
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crc_ff <= `FIP_CRC_INIT;
    end else if (state_ff == FIP_IDLE) begin
      crc_ff <= `FIP_CRC_INIT;
    end else if (push && idx_ff < `FIP_OFS_CRC) begin
      crc_ff <= fip_crc_step(crc_ff, nxt_byte);
    end
  end

  // ---------------------------------------------------------------
  // Two-entry output buffer
  // ---------------------------------------------------------------
  assign pop = head_vld_ff && link.ready;

  // Head feeds the link; tail catches the byte pushed while head is stalled
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      head_ff     <= 9'h000;
      head_vld_ff <= 1'b0;
      tail_ff     <= 9'h000;
      tail_vld_ff <= 1'b0;
    end else if (pop || !head_vld_ff) begin
      if (tail_vld_ff) begin
        head_ff     <= tail_ff;
        head_vld_ff <= 1'b1;
        tail_ff     <= {idx_ff == 8'd0, nxt_byte};
        tail_vld_ff <= push;
      end else begin
        head_ff     <= {idx_ff == 8'd0, nxt_byte};
        head_vld_ff <= push;
      end
    end else if (push) begin
      tail_ff     <= {idx_ff == 8'd0, nxt_byte};
      tail_vld_ff <= 1'b1;
    end
  end

  // Busy until the last byte has left the buffer
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy      <= 1'b0;
      o_frame_num <= 2'h0;
    end else begin
      o_busy      <= (state_ff == FIP_SEND) || (state_ff == FIP_IDLE && i_insert) ||
                     tail_vld_ff || (head_vld_ff && !pop);
      o_frame_num <= fnum_ff;
    end
  end

  assign link.data  = head_ff[7:0];
  assign link.sop   = head_ff[8];
  assign link.valid = head_vld_ff;

endmodule // fip_gen

// *** rtl/fip_sync.sv ***
// Sync-system end: parses and checks the packet and applies its fields per frame
`timescale 1ns/1ps
`include "fip_map.svh"
module fip_sync
  import fip_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_ts_packet,
  output logic             o_pkt_ok,
  output logic             o_pkt_err,
  output logic             o_frame_start,
  output logic [15:0]      o_pointer,
  output logic             o_periodic,
  output logic [23:0]      o_timestamp,
  output logic [23:0]      o_latency,
  output logic [31:0]      o_signal,
  output logic [1:0]       o_frame_num,
  fip_if.sync              link
);
  import fip_pkg::*;

  logic        take;
  logic [7:0]  cur_idx;
  logic [7:0]  idx_ff;
  logic        in_pkt_ff;
  logic        bad_ff;
  logic        mine_ff;
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;
  logic [7:0]  len_ff;
  logic [15:0] ptr_ff;
  logic        per_ff;
  logic [23:0] ts_ff;
  logic [23:0] lat_ff;
  logic [31:0] sig_ff;
  logic        armed_ff;
  logic [15:0] cnt_ff;
  logic [15:0] pend_ptr_ff;
  logic        pend_per_ff;
  logic [23:0] pend_ts_ff;
  logic [23:0] pend_lat_ff;
  logic [31:0] pend_sig_ff;
  logic [31:0] sig_stage_ff;

  // ---------------------------------------------------------------
  // Byte intake
  // ---------------------------------------------------------------
  assign take    = link.valid && link.ready;
  assign cur_idx = link.sop ? 8'h00 : idx_ff + 8'h01;
  assign nxt_crc = fip_crc_step(link.sop ? `FIP_CRC_INIT : crc_ff, link.data);

  // A new start mid-packet discards the partial one
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.ready <= 1'b0;
      idx_ff     <= 8'h00;
      in_pkt_ff  <= 1'b0;
      crc_ff     <= `FIP_CRC_INIT;
    end else begin
      link.ready <= 1'b1;
      if (take && (link.sop || in_pkt_ff)) begin
        idx_ff    <= cur_idx;
        in_pkt_ff <= (cur_idx != `FIP_PKT_LAST);
        crc_ff    <= nxt_crc;
      end
    end
  end

  // Field capture and checks; reserved scheme codes are rejected, not decoded
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bad_ff  <= 1'b0;
      mine_ff <= 1'b0;
      len_ff  <= 8'h00;
      ptr_ff  <= 16'h0000;
      per_ff  <= 1'b0;
      ts_ff   <= 24'h000000;
      lat_ff  <= 24'h000000;
      sig_ff  <= 32'h00000000;
    end else if (take && (link.sop || in_pkt_ff)) begin
      if (link.sop) begin
        bad_ff  <= (link.data != `FIP_SYNC_BYTE);
        mine_ff <= 1'b1;
      end
      unique case (cur_idx)
        8'd1: mine_ff <= mine_ff && (link.data[4:0] == 5'(`FIP_PID >> 8));
        8'd2: mine_ff <= mine_ff && (link.data == 8'(`FIP_PID & 13'h00FF));
        8'd4: bad_ff  <= bad_ff || (link.data != `FIP_SCHEME_SFN);
        8'd5: begin
          len_ff <= link.data;
          bad_ff <= bad_ff || (link.data > `FIP_SEC_LEN_MAX);
        end
        8'd6:  ptr_ff[15:8] <= link.data;
        8'd7:  ptr_ff[7:0]  <= link.data;
        8'd8:  per_ff       <= link.data[7];
        8'd9:  bad_ff       <= bad_ff || (link.data[0] != `FIP_HANDHELD);
        8'd10: ts_ff[23:16] <= link.data;
        8'd11: ts_ff[15:8]  <= link.data;
        8'd12: ts_ff[7:0]   <= link.data;
        8'd13: begin
          lat_ff[23:16] <= link.data;
          bad_ff        <= bad_ff || (ts_ff > `FIP_TIME_MAX);
        end
        8'd14: lat_ff[15:8] <= link.data;
        8'd15: lat_ff[7:0]  <= link.data;
        8'd16: begin
          sig_ff[31:24] <= link.data;
          bad_ff        <= bad_ff || (lat_ff > `FIP_TIME_MAX);
        end
        8'd17: sig_ff[23:16] <= link.data;
        8'd18: sig_ff[15:8]  <= link.data;
        8'd19: sig_ff[7:0]   <= link.data;
        default: begin
          // Addressing blocks change the CRC position; section length finds it
          if (len_ff <= `FIP_SEC_LEN_MAX && cur_idx == `FIP_OFS_LEN + len_ff) begin
            bad_ff <= bad_ff || (nxt_crc != 32'h00000000);
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Verdict, pointer countdown and frame-aligned application
  // ---------------------------------------------------------------
  // Fields wait for the designated frame; signalling waits one frame more
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pkt_ok      <= 1'b0;
      o_pkt_err     <= 1'b0;
      o_frame_start <= 1'b0;
      armed_ff      <= 1'b0;
      cnt_ff        <= 16'h0000;
      pend_ptr_ff   <= 16'h0000;
      pend_per_ff   <= 1'b0;
      pend_ts_ff    <= 24'h000000;
      pend_lat_ff   <= 24'h000000;
      pend_sig_ff   <= 32'h00000000;
      sig_stage_ff  <= 32'h00000000;
      o_pointer     <= 16'h0000;
      o_periodic    <= 1'b0;
      o_timestamp   <= 24'h000000;
      o_latency     <= 24'h000000;
      o_signal      <= 32'h00000000;
      o_frame_num   <= 2'h0;
    end else begin
      o_pkt_ok      <= 1'b0;
      o_pkt_err     <= 1'b0;
      o_frame_start <= 1'b0;
      if (take && in_pkt_ff && cur_idx == `FIP_PKT_LAST && mine_ff) begin
        o_pkt_ok  <= !bad_ff;
        o_pkt_err <= bad_ff;
        if (!bad_ff) begin
          armed_ff    <= 1'b1;
          cnt_ff      <= ptr_ff;
          pend_ptr_ff <= ptr_ff;
          pend_per_ff <= per_ff;
          pend_ts_ff  <= ts_ff;
          pend_lat_ff <= lat_ff;
          pend_sig_ff <= sig_ff;
        end
      end else if (armed_ff && i_ts_packet) begin
        if (cnt_ff == 16'h0000) begin
          armed_ff      <= 1'b0;
          o_frame_start <= 1'b1;
          o_pointer     <= pend_ptr_ff;
          o_periodic    <= pend_per_ff;
          o_timestamp   <= pend_ts_ff;
          o_latency     <= pend_lat_ff;
          sig_stage_ff  <= pend_sig_ff;
          o_signal      <= sig_stage_ff;
          o_frame_num   <= sig_stage_ff[31:30];
        end else begin
          cnt_ff <= cnt_ff - 16'h0001;
        end
      end
    end
  end

endmodule // fip_sync

// *** testbench/fip_link_chk.sv ***
// Checker of the byte link between the packet generator and the parser
`timescale 1ns/1ps
module fip_link_chk (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic [7:0] data,
  input wire logic       sop,
  input wire logic       valid,
  input wire logic       ready
);
  // ----------------------------------------------------------
  // Byte position tracking
  // ----------------------------------------------------------
  logic [7:0] cnt_ff;
  logic       seen_ff;
  wire        take = valid && ready;

  // Count sticks at 188 so a packet that runs long is still caught
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 8'h00;
    end else if (take && sop) begin
      cnt_ff <= 8'h01;
    end else if (take && cnt_ff != 8'h00 && cnt_ff != 8'hBC) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // First packet start seen; spacing is only judged after it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_ff <= 1'h0;
    end else if (take && sop) begin
      seen_ff <= 1'h1;
    end
  end

  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_sync_byte: assert property (take && sop |-> data == 8'h47)
    else $error("first byte of packet is not the sync byte");
  a_pid_high: assert property (take && !sop && cnt_ff == 8'h01 |-> data == 8'h60)
    else $error("start and priority bits wrong");
  a_pid_low: assert property (take && !sop && cnt_ff == 8'h02 |-> data == 8'h15)
    else $error("packet identifier wrong");
  a_hdr_ctrl: assert property (take && !sop && cnt_ff == 8'h03 |-> data[7:4] == 4'h1)
    else $error("scrambling or adaptation control wrong");
  a_scheme_code: assert property (take && !sop && cnt_ff == 8'h04 |-> data == 8'h00)
    else $error("sync scheme code wrong");
  a_sec_len: assert property (take && !sop && cnt_ff == 8'h05 |-> data == 8'h13)
    else $error("payload byte count wrong");
  a_handheld_bit: assert property (take && !sop && cnt_ff == 8'h09 |-> data[0])
    else $error("handheld marker not set");
  a_addr_none: assert property (take && !sop && cnt_ff == 8'h14 |-> data == 8'h00)
    else $error("address block length not zero");
  a_pad_bytes: assert property (take && cnt_ff >= 8'h19 && cnt_ff < 8'hBC |-> data == 8'hFF)
    else $error("pad byte is not FF");
  a_sop_spacing: assert property (take && seen_ff |-> sop == (cnt_ff == 8'hBC))
    else $error("packet is not 188 bytes long");
  a_ready_up: assert property ($past(i_rst_n) |-> ready)
    else $error("parser not ready after reset");
endmodule // fip_link_chk

// *** testbench/tb_top.sv ***
// Self-checking bench of the packet generator and parser joined back to back
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------
  logic        i_clock, i_rst_n, ins, per, tsp, busy, s_ok, s_err, s_fs, s_per, x_ok, x_err;
  logic [15:0] ptr, s_ptr;
  logic [23:0] ts, lat, s_ts, s_lat;
  logic [29:0] sig;
  logic [31:0] s_sig, prev_sig;
  logic [1:0]  g_fn, s_fn;
  logic [7:0]  exp_b [188];
  logic [7:0]  got_b [188];
  logic [7:0]  fi [8] = '{8'h00, 8'h00, 8'h04, 8'h05, 8'h09, 8'h0A, 8'h15, 8'h02};
  logic [7:0]  fv [8] = '{8'h47, 8'h46, 8'h01, 8'hB7, 8'h00, 8'hFF, 8'h00, 8'h16};
  int          got_n = 0, sop_n = 0, ok_n = 0, err_n = 0, fs_n = 0, xok_n = 0, xerr_n = 0;
  int          cyc = 0, fail_count = 0, check_count = 0;
  fip_if lnk ();
  fip_if xlnk ();
  fip_gen fip_gen_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_insert(ins), .i_pointer(ptr),
    .i_periodic(per), .i_timestamp(ts), .i_latency(lat), .i_signal(sig), .o_busy(busy),
    .o_frame_num(g_fn), .link(lnk));
  fip_sync fip_sync_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ts_packet(tsp), .o_pkt_ok(s_ok),
    .o_pkt_err(s_err), .o_frame_start(s_fs), .o_pointer(s_ptr), .o_periodic(s_per),
    .o_timestamp(s_ts), .o_latency(s_lat), .o_signal(s_sig), .o_frame_num(s_fn), .link(lnk));
  // Second parser fed by the bench with one good packet, one foreign packet and deliberately broken ones
  fip_sync fip_sync_x_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ts_packet(1'h0),
    .o_pkt_ok(x_ok), .o_pkt_err(x_err), .o_frame_start(), .o_pointer(), .o_periodic(),
    .o_timestamp(), .o_latency(), .o_signal(), .o_frame_num(), .link(xlnk));
  fip_link_chk fip_link_chk_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .data(lnk.data),
    .sop(lnk.sop), .valid(lnk.valid), .ready(lnk.ready));

  // 50 MHz clock
  initial begin
    i_clock = 1'h0;
    forever #10 i_clock = ~i_clock;
  end

  // Capture link bytes, count pulses, and cut a hang short
  always @(posedge i_clock) begin
    cyc++;
    if (lnk.valid === 1'h1 && lnk.ready === 1'h1) begin
      if (lnk.sop === 1'h1) begin
        got_n = 0;
        sop_n++;
      end
      if (got_n < 188) got_b[got_n] = lnk.data;
      got_n++;
    end
    if (s_ok === 1'h1) ok_n++;
    if (s_err === 1'h1) err_n++;
    if (s_fs === 1'h1) fs_n++;
    if (x_ok === 1'h1) xok_n++;
    if (x_err === 1'h1) xerr_n++;
    if (cyc == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = (c[31] ^ d[i]) ? ((c << 1) ^ 32'h04C11DB7) : (c << 1);
    return c;
  endfunction
  function automatic logic [23:0] clamp(input logic [23:0] v);
    return (v > 24'h98967F) ? 24'h98967F : v;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic recrc();
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 21; i++) c = crc_b(c, exp_b[i]);
    {exp_b[21], exp_b[22], exp_b[23], exp_b[24]} = c;
  endtask
  // Whole expected packet from the current field inputs
  task automatic build(input logic [3:0] cc, input logic [31:0] s);
    for (int i = 0; i < 188; i++) exp_b[i] = 8'hFF;
    {exp_b[0], exp_b[1], exp_b[2], exp_b[3]} = {8'h47, 8'h60, 8'h15, 4'h1, cc};
    {exp_b[4], exp_b[5], exp_b[6], exp_b[7]} = {8'h00, 8'h13, ptr};
    {exp_b[8], exp_b[9]} = {per, 14'h0000, 1'h1};
    {exp_b[10], exp_b[11], exp_b[12]} = clamp(ts);
    {exp_b[13], exp_b[14], exp_b[15]} = clamp(lat);
    {exp_b[16], exp_b[17], exp_b[18], exp_b[19], exp_b[20]} = {s, 8'h00};
    recrc();
  endtask
  task automatic pulse_ts();
    tsp = 1'h1;
    @(negedge i_clock);
    tsp = 1'h0;
    @(negedge i_clock);
  endtask
  // One generated packet, parsed, then applied at the frame the pointer names
  task automatic send_one(input int k);
    int n, b4, f4;
    ptr = 16'($urandom_range(0, 3));
    per = 1'($urandom);
    ts = (k == 1) ? 24'hFFFFFF : (k == 3) ? 24'h98967F : 24'($urandom);
    lat = (k == 1) ? 24'h989680 : 24'($urandom_range(32'h00FFFFFF, 32'h00000100));
    sig = 30'($urandom);
    b4 = sop_n;
    chk("gen frame num", k[1:0], g_fn);
    ins = 1'h1;
    @(negedge i_clock);
    ins = 1'h0;
    if (k == 2) begin
      repeat (40) @(negedge i_clock);
      ins = 1'h1;  // Dropped while busy
      @(negedge i_clock);
      ins = 1'h0;
    end
    for (n = 0; n < 400 && !(sop_n == b4 + 1 && got_n >= 188 && busy === 1'h0); n++)
      @(negedge i_clock);
    repeat (3) @(negedge i_clock);
    build(4'(k), {k[1:0], sig});
    chk("sop count", b4 + 1, sop_n);
    for (n = 0; n < 188; n++) chk("link byte", exp_b[n], got_b[n]);
    chk("ok pulses", k + 1, ok_n);
    chk("err pulses", 0, err_n);
    f4 = fs_n;
    repeat (ptr) pulse_ts();
    chk("early frame start", f4, fs_n);
    pulse_ts();
    repeat (2) @(negedge i_clock);
    chk("frame start", f4 + 1, fs_n);
    chk("pointer", ptr, s_ptr);
    chk("periodic", per, s_per);
    chk("timestamp", clamp(ts), s_ts);
    chk("latency", clamp(lat), s_lat);
    chk("signal", prev_sig, s_sig);
    chk("frame num", prev_sig[31:30], s_fn);
    prev_sig = {k[1:0], sig};
  endtask
  // Bench stands in for a generator; data lines are scrambled once released, valid and sop go low
  task automatic send_raw();
    for (int i = 0; i < 188; i++) begin
      xlnk.valid = 1'h1;
      xlnk.sop = (i == 0);
      xlnk.data = exp_b[i];
      do @(posedge i_clock); while (xlnk.ready !== 1'h1);
      @(negedge i_clock);
    end
    xlnk.valid = 1'h0;
    xlnk.sop = 1'h0;
    xlnk.data = ~xlnk.data;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    int o, e;
    void'($urandom(98));
    {i_rst_n, ins, tsp, per, ptr, ts, lat, sig, prev_sig} = '0;
    {xlnk.valid, xlnk.sop, xlnk.data} = '0;
    repeat (8) @(negedge i_clock);
    i_rst_n = 1'h1;
    @(negedge i_clock);
    chk("ready", 1'h1, lnk.ready);
    for (int k = 0; k < 6; k++) send_one(k);
    // Good, bad sync byte, scheme, length, marker, time, CRC, foreign identifier
    for (int k = 0; k < 8; k++) begin
      o = xok_n;
      e = xerr_n;
      build(4'h0, 32'h0);
      exp_b[fi[k]] = fv[k];
      recrc();
      if (k == 6) exp_b[21] = ~exp_b[21];
      send_raw();
      repeat (3) @(negedge i_clock);
      chk("fault ok", k == 0, xok_n - o);
      chk("fault err", k > 0 && k < 7, xerr_n - e);
    end
    stop_test();
  end
endmodule // tb_top
